// ---- pkg/cmtc_pkg.sv ----
package cmtc_pkg;
   localparam int          CMTC_CHANNELS     = 5;
   localparam int          CMTC_AW           = 8;
   // register byte offsets
   localparam logic [7:0]  CMTC_RUN_OFS      = 8'h00;
   localparam logic [7:0]  CMTC_IRQ_STAT_OFS = 8'h04;
   localparam logic [7:0]  CMTC_IRQ_MASK_OFS = 8'h08;
   localparam logic [7:0]  CMTC_CH_BASE      = 8'h10;
   localparam logic [7:0]  CMTC_CH_STRIDE    = 8'h10;
   localparam logic [7:0]  CMTC_CSR_SUB      = 8'h00;
   localparam logic [7:0]  CMTC_CNT_SUB      = 8'h04;
   localparam logic [7:0]  CMTC_CONST_SUB    = 8'h08;
   // control/status field positions
   localparam int          CMTC_MATCH_BIT    = 15;
   localparam int          CMTC_WRAP_BIT     = 14;
   localparam int          CMTC_WIDTH_BIT    = 9;
   localparam int          CMTC_MODE_BIT     = 8;
   localparam int          CMTC_REQ_LSB      = 4;
   localparam int          CMTC_CLKSEL_LSB   = 0;
   // writable bits: 9, 8, 5:4, 2:0
   localparam logic [15:0] CMTC_CSR_WMASK    = 16'h0337;
   localparam logic [15:0] CMTC_RUN_WMASK    = 16'h001F;
   // reset values
   localparam logic [15:0] CMTC_CSR_RESET    = 16'h0000;
   localparam logic [31:0] CMTC_CNT_RESET    = 32'h00000000;
   localparam logic [31:0] CMTC_CONST_RESET  = 32'hFFFFFFFF;
   // prescaler divide counts, cycles of clk
   localparam int          CMTC_DIV_A        = 8;
   localparam int          CMTC_DIV_B        = 32;
   localparam int          CMTC_DIV_C        = 128;
   localparam int          CMTC_PRE_W        = 7;
   typedef enum logic [1:0] {
      CMTC_REQ_NONE = 2'b00,
      CMTC_REQ_DMA  = 2'b01,
      CMTC_REQ_IRQ  = 2'b10,
      CMTC_REQ_BAD  = 2'b11
   } cmtc_req_t;
endpackage

// ---- hdl/cmtc_prescaler.sv ----
`timescale 1ns/1ps
module cmtc_prescaler
   import cmtc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   output logic [2:0]      tick_r
);
   logic [CMTC_PRE_W-1:0] pre_r;
   logic [CMTC_PRE_W-1:0] pre_nxt;
   logic [2:0]            tick_nxt;

   // one shared free-running divider keeps all channel ticks phase-aligned
   assign pre_nxt  = pre_r + CMTC_PRE_W'(1);
   assign tick_nxt = {pre_r == CMTC_PRE_W'(CMTC_DIV_C - 1),
                      pre_r[4:0] == 5'(CMTC_DIV_B - 1),
                      pre_r[2:0] == 3'(CMTC_DIV_A - 1)};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_r  <= '0;
         tick_r <= 3'h0;
      end else begin
         pre_r  <= pre_nxt;
         tick_r <= tick_nxt;
      end
   end
endmodule

// ---- hdl/cmtc_channel.sv ----
`timescale 1ns/1ps
module cmtc_channel
   import cmtc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        run,
   input  wire logic        tick,
   input  wire logic        width16,
   input  wire logic        freerun,
   input  wire logic        match_flag,
   input  wire logic        cnt_we,
   input  wire logic        const_we,
   input  wire logic [31:0] wdata,
   output logic [31:0]      cnt_r,
   output logic [31:0]      const_r,
   output logic             match_ev_r,
   output logic             wrap_ev_r
);
   logic [31:0] cnt_nxt;
   logic [31:0] const_nxt;
   logic        step;
   logic        hit;
   logic        wrap;

   // one-shot holds while the match flag stays set
   assign step = run && tick && (freerun || !match_flag); // see R05, R14, R16
   assign hit  = width16 ? (cnt_r[15:0] == const_r[15:0])
                         : (cnt_r == const_r); // see R09
   assign wrap = width16 ? (cnt_r[15:0] == 16'hFFFF) : (cnt_r == 32'hFFFFFFFF);

   always_comb begin
      cnt_nxt = cnt_r;
      if (cnt_we) begin
         cnt_nxt = wdata;
      end else if (step) begin
         if (hit) begin
            cnt_nxt = CMTC_CNT_RESET; // see R16
         end else begin
            cnt_nxt = width16 ? {16'h0000, cnt_r[15:0] + 16'h0001} // see R08
                              : cnt_r + 32'h00000001;
         end
      end
   end
   assign const_nxt = const_we ? wdata : const_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r      <= CMTC_CNT_RESET;
         const_r    <= CMTC_CONST_RESET;
         match_ev_r <= 1'b0;
         wrap_ev_r  <= 1'b0;
      end else begin
         cnt_r      <= cnt_nxt;
         const_r    <= const_nxt;
         match_ev_r <= step && hit; // see R03
         wrap_ev_r  <= step && wrap; // see R06, R15
      end
   end

   chk_oneshot_hold: assert property (@(posedge clk) disable iff (!reset_n) // see R05
      (!freerun && match_flag && !cnt_we) |=> cnt_r == $past(cnt_r))
      else $error("one-shot counter moved while match flag set");
   chk_match_clear: assert property (@(posedge clk) disable iff (!reset_n) // see R16
      (step && hit && !cnt_we) |=> cnt_r == 32'h0 && match_ev_r)
      else $error("counter not cleared on match");
   chk_width_upper: assert property (@(posedge clk) disable iff (!reset_n) // see R08
      (width16 && step && !cnt_we) |=> cnt_r[31:16] == 16'h0000)
      else $error("16-bit counter carried into upper half");
endmodule

// ---- hdl/cmtc_timer.sv ----
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Function
// R01: run register bits 4..0 halt (0) or run (1) each channel counter.
// R02: reserved run bits 15..5 and control bits 13..10 read zero; software writes zero.
// R03: match flag bit 15 sets when counter equals the constant register.
// R04: writing 1 to match flag does nothing; it clears by writing 0 after reading it as 1.
// R05: in one-shot mode counting resumes once the match flag is cleared.
// R06: wrap flag bit 14 sets when the counter overflows to zero; writing 1 is ignored.
// R07: wrap flag clears only by writing 0 after reading it as 1.
// R08: bit 9 picks counter width, 0 for 32 bits and 1 for 16 bits.
// R09: the chosen width also sets how many constant bits take part in compare.
// R10: bit 8 picks mode, 0 one-shot and 1 free-running.
// R11: software must not change non-flag control bits while the channel runs.
// R12: each of five channels has its own 16-bit control/status register.
// R13: bits 5:4 gate match requests: 00 none, 01 dma, 10 interrupt, 11 prohibited.
// R14: bits 2:0 pick increment clock clk/8, clk/32, clk/128; other codes prohibited.
// R15: overflow is detected when the counter wraps to zero with constant at all ones.
// R16: on match the counter returns to zero; one-shot holds until the flag clears.
module cmtc_timer
   import cmtc_pkg::*;
#(
   parameter int NCH = CMTC_CHANNELS
)(
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic [CMTC_AW-1:0] addr,
   input  wire logic [31:0]        wdata,
   input  wire logic               wr,
   input  wire logic               rd,
   output logic [31:0]             rdata_r,
   output logic                    irq_r,
   output logic [NCH-1:0]          dma_req_r,
   output logic [NCH-1:0]          ch_irq_r
);
   // status register holds match bits 7:0 and wrap bits 15:8, so eight channels at most
   generate
      if (NCH < 1 || NCH > 8) begin : g_bad_nch
         $error("cmtc_timer: NCH out of range");
      end
   endgenerate

   logic [15:0]     run_r;
   logic [15:0]     csr_r     [NCH];
   logic [NCH-1:0]  seen_m_r;
   logic [NCH-1:0]  seen_w_r;
   logic [15:0]     istat_r;
   logic [15:0]     imask_r;
   logic [31:0]     rdata_nxt;
   logic [2:0]      tick;
   logic [31:0]     cnt_v     [NCH];
   logic [31:0]     const_v   [NCH];
   logic [NCH-1:0]  match_ev;
   logic [NCH-1:0]  wrap_ev;
   logic [NCH-1:0]  ch_sel;
   logic [NCH-1:0]  dma_nxt;
   logic [NCH-1:0]  chirq_nxt;
   logic [15:0]     istat_nxt;
   logic            run_hit;
   logic            stat_hit;
   logic            mask_hit;

   function automatic logic [7:0] ch_base(input int n);
      ch_base = 8'(CMTC_CH_BASE + n * CMTC_CH_STRIDE);
   endfunction

   function automatic logic tick_sel(input logic [2:0] clk_code, input logic [2:0] t);
      // prohibited codes give no tick so the counter stalls
      tick_sel = (clk_code == 3'h0) ? t[0] : (clk_code == 3'h1) ? t[1] :
                 (clk_code == 3'h2) ? t[2] : 1'b0; // see R14
   endfunction

   assign run_hit  = (addr == CMTC_RUN_OFS);
   assign stat_hit = (addr == CMTC_IRQ_STAT_OFS);
   assign mask_hit = (addr == CMTC_IRQ_MASK_OFS);

   cmtc_prescaler u_pre (
      .clk     (clk),
      .reset_n (reset_n),
      .tick_r  (tick)
   );

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         logic csr_hit;
         logic cnt_hit;
         logic const_hit;
         logic wr_csr;
         logic rd_csr;
         logic clr_m;
         logic clr_w;
         logic [15:0] csr_nxt;
         logic [1:0]  req;

         assign csr_hit   = (addr == ch_base(g) + CMTC_CSR_SUB);
         assign cnt_hit   = (addr == ch_base(g) + CMTC_CNT_SUB);
         assign const_hit = (addr == ch_base(g) + CMTC_CONST_SUB);
         assign ch_sel[g] = csr_hit;
         assign wr_csr    = wr && csr_hit;
         assign rd_csr    = rd && csr_hit;
         assign clr_m     = wr_csr && !wdata[CMTC_MATCH_BIT] && seen_m_r[g]; // see R04
         assign clr_w     = wr_csr && !wdata[CMTC_WRAP_BIT] && seen_w_r[g]; // see R07
         assign req       = csr_r[g][CMTC_REQ_LSB +: 2];

         // writes touch only control bits; flags are set-wins over clear
         always_comb begin
            csr_nxt = csr_r[g];
            if (wr_csr) begin
               csr_nxt = (csr_r[g] & ~CMTC_CSR_WMASK) | (wdata[15:0] & CMTC_CSR_WMASK); // see R02
            end
            csr_nxt[CMTC_MATCH_BIT] = match_ev[g] || (csr_r[g][CMTC_MATCH_BIT] && !clr_m);
            csr_nxt[CMTC_WRAP_BIT]  = wrap_ev[g] || (csr_r[g][CMTC_WRAP_BIT] && !clr_w);
         end

         assign dma_nxt[g]   = match_ev[g] && (req == CMTC_REQ_DMA); // see R13
         assign chirq_nxt[g] = match_ev[g] && (req == CMTC_REQ_IRQ); // see R13

         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               csr_r[g]    <= CMTC_CSR_RESET; // see R12
               seen_m_r[g] <= 1'b0;
               seen_w_r[g] <= 1'b0;
            end else begin
               csr_r[g]    <= csr_nxt;
               // read-as-1 arms the clear; a write or a cleared flag disarms it
               seen_m_r[g] <= rd_csr ? csr_r[g][CMTC_MATCH_BIT]
                            : (wr_csr ? 1'b0 : seen_m_r[g] && csr_r[g][CMTC_MATCH_BIT]);
               seen_w_r[g] <= rd_csr ? csr_r[g][CMTC_WRAP_BIT]
                            : (wr_csr ? 1'b0 : seen_w_r[g] && csr_r[g][CMTC_WRAP_BIT]);
            end
         end

         cmtc_channel u_ch (
            .clk        (clk),
            .reset_n    (reset_n),
            .run        (run_r[g]), // see R01
            .tick       (tick_sel(csr_r[g][CMTC_CLKSEL_LSB +: 3], tick)),
            .width16    (csr_r[g][CMTC_WIDTH_BIT]), // see R08
            .freerun    (csr_r[g][CMTC_MODE_BIT]), // see R10
            .match_flag (csr_r[g][CMTC_MATCH_BIT]),
            .cnt_we     (wr && cnt_hit),
            .const_we   (wr && const_hit),
            .wdata      (wdata),
            .cnt_r      (cnt_v[g]),
            .const_r    (const_v[g]),
            .match_ev_r (match_ev[g]),
            .wrap_ev_r  (wrap_ev[g])
         );

         chk_no_set_by_write: assert property (@(posedge clk) disable iff (!reset_n) // see R04
            (!csr_r[g][CMTC_MATCH_BIT] && !match_ev[g]) |=> !csr_r[g][CMTC_MATCH_BIT])
            else $error("match flag set without a match");
         chk_clear_needs_read: assert property (@(posedge clk) disable iff (!reset_n) // see R07
            (csr_r[g][CMTC_WRAP_BIT] && !seen_w_r[g]) |=> csr_r[g][CMTC_WRAP_BIT])
            else $error("wrap flag cleared without prior read");
         chk_match_sets_flag: assert property (@(posedge clk) disable iff (!reset_n) // see R03
            match_ev[g] |=> csr_r[g][CMTC_MATCH_BIT])
            else $error("match event did not set flag");
         chk_wrap_sets_flag: assert property (@(posedge clk) disable iff (!reset_n) // see R06
            wrap_ev[g] |=> csr_r[g][CMTC_WRAP_BIT])
            else $error("wrap event did not set flag");
         chk_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n) // see R02
            csr_r[g][13:10] == 4'h0 && csr_r[g][7:6] == 2'h0 && csr_r[g][3] == 1'b0)
            else $error("reserved control bits not zero");

         sequence s_read_match;
            rd_csr && csr_r[g][CMTC_MATCH_BIT];
         endsequence
         sequence s_match_zero_write;
            wr_csr && !wdata[CMTC_MATCH_BIT] && !match_ev[g];
         endsequence
         sequence s_read_wrap;
            rd_csr && csr_r[g][CMTC_WRAP_BIT];
         endsequence
         sequence s_wrap_zero_write;
            wr_csr && !wdata[CMTC_WRAP_BIT] && !wrap_ev[g];
         endsequence

         chk_match_read_clear: assert property (@(posedge clk) disable iff (!reset_n) // see R04
            s_read_match ##1 s_match_zero_write |=> !csr_r[g][CMTC_MATCH_BIT])
            else $error("match flag kept after read and zero write");
         chk_wrap_read_clear: assert property (@(posedge clk) disable iff (!reset_n) // see R07
            s_read_wrap ##1 s_wrap_zero_write |=> !csr_r[g][CMTC_WRAP_BIT])
            else $error("wrap flag kept after read and zero write");
         chk_dma_pulse: assert property (@(posedge clk) disable iff (!reset_n) // see R13
            (match_ev[g] && req == CMTC_REQ_DMA) |=> dma_req_r[g])
            else $error("dma request missing on match");
         chk_irq_pulse: assert property (@(posedge clk) disable iff (!reset_n) // see R13
            (match_ev[g] && req == CMTC_REQ_IRQ) |=> ch_irq_r[g])
            else $error("channel interrupt missing on match");
         chk_req_gated: assert property (@(posedge clk) disable iff (!reset_n) // see R13
            (!match_ev[g] || req == CMTC_REQ_NONE || req == CMTC_REQ_BAD)
            |=> !dma_req_r[g] && !ch_irq_r[g])
            else $error("request raised while gated off");
         chk_run_halts: assert property (@(posedge clk) disable iff (!reset_n) // see R01
            (!run_r[g] && !(wr && cnt_hit)) |=> cnt_v[g] == $past(cnt_v[g]))
            else $error("halted counter moved");
         chk_status_sets: assert property (@(posedge clk) disable iff (!reset_n) // see R03
            match_ev[g] |=> istat_r[g])
            else $error("status bit not set on match");
      end
   endgenerate

   // interrupt status: bit n = match of channel n, bit 8+n = wrap of channel n
   always_comb begin
      istat_nxt = istat_r;
      if (wr && stat_hit) begin
         istat_nxt = istat_r & ~wdata[15:0];
      end
      for (int i = 0; i < NCH; i++) begin
         if (match_ev[i]) begin
            istat_nxt[i] = 1'b1;
         end
         if (wrap_ev[i]) begin
            istat_nxt[8 + i] = 1'b1;
         end
      end
   end

   always_comb begin
      rdata_nxt = 32'h00000000;
      if (run_hit) begin
         rdata_nxt = {16'h0000, run_r};
      end else if (stat_hit) begin
         rdata_nxt = {16'h0000, istat_r};
      end else if (mask_hit) begin
         rdata_nxt = {16'h0000, imask_r};
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (ch_sel[i]) begin
               rdata_nxt = {16'h0000, csr_r[i]};
            end else if (addr == ch_base(i) + CMTC_CNT_SUB) begin
               rdata_nxt = cnt_v[i];
            end else if (addr == ch_base(i) + CMTC_CONST_SUB) begin
               rdata_nxt = const_v[i];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         run_r     <= 16'h0000;
         istat_r   <= 16'h0000;
         imask_r   <= 16'h0000;
         rdata_r   <= 32'h00000000;
         irq_r     <= 1'b0;
         dma_req_r <= '0;
         ch_irq_r  <= '0;
      end else begin
         if (wr && run_hit) begin
            run_r <= wdata[15:0] & CMTC_RUN_WMASK; // see R01, R02
         end
         if (wr && mask_hit) begin
            imask_r <= wdata[15:0];
         end
         istat_r   <= istat_nxt;
         rdata_r   <= rd ? rdata_nxt : 32'h00000000;
         irq_r     <= |(istat_r & imask_r);
         dma_req_r <= dma_nxt;
         ch_irq_r  <= chirq_nxt;
      end
   end

   chk_run_reserved: assert property (@(posedge clk) disable iff (!reset_n) // see R02
      run_r[15:5] == 11'h000)
      else $error("run register reserved bits set");
   chk_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
      |(istat_r & imask_r) |=> irq_r)
      else $error("interrupt not raised");
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
   import cmtc_pkg::*;
   ;
   logic               clk;
   logic               reset_n;
   logic [CMTC_AW-1:0] addr;
   logic [31:0]        wdata;
   logic               wr;
   logic               rd;
   logic [31:0]        rdata_r;
   logic               irq_r;
   logic [4:0]         dma_req_r;
   logic [4:0]         ch_irq_r;
   logic [4:0]         seen_dma;
   logic [4:0]         seen_irq;
   logic [31:0]        d;
   int                 fail_count;
   int                 check_count;
   int                 cycles;

   cmtc_timer #(.NCH(5)) dut (
      .clk       (clk),
      .reset_n   (reset_n),
      .addr      (addr),
      .wdata     (wdata),
      .wr        (wr),
      .rd        (rd),
      .rdata_r   (rdata_r),
      .irq_r     (irq_r),
      .dma_req_r (dma_req_r),
      .ch_irq_r  (ch_irq_r)
   );

   always #20 clk = ~clk;

   // request pulses last one cycle, so they are gathered here and judged later
   always @(posedge clk) begin
      seen_dma <= seen_dma | dma_req_r;
      seen_irq <= seen_irq | ch_irq_r;
      cycles   <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr    <= 1'h1;
      addr  <= a;
      wdata <= v;
      @(posedge clk);
      wr    <= 1'h0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd   <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'h0;
      #1 v = rdata_r;
   endtask

   function automatic logic [7:0] csr_a(input int ch);
      return CMTC_CH_BASE + CMTC_CH_STRIDE * ch[7:0] + CMTC_CSR_SUB;
   endfunction

   // polls a control/status register until all bits of m are set, bounded
   task automatic wait_csr(input int ch, input logic [31:0] m, output logic [31:0] v);
      for (int i = 0; i < 80; i++) begin
         bus_rd(csr_a(ch), v);
         if ((v & m) === m) break;
      end
   endtask

   task automatic t_reset_values();
      bus_rd(CMTC_RUN_OFS, d); check(d, 32'h0);
      for (int ch = 0; ch < 5; ch++) begin
         bus_rd(csr_a(ch), d); check(d, 32'h0);
         bus_rd(csr_a(ch) + CMTC_CNT_SUB, d); check(d, 32'h0);
         bus_rd(csr_a(ch) + CMTC_CONST_SUB, d); check(d, 32'hFFFFFFFF);
      end
      bus_wr(8'hF0, 32'hFFFFFFFF);
      bus_rd(8'hF0, d); check(d, 32'h0);
      bus_wr(CMTC_RUN_OFS, 32'h0000FFFF);
      bus_rd(CMTC_RUN_OFS, d); check(d, 32'h0000001F);
      bus_wr(CMTC_RUN_OFS, 32'h0);
      bus_wr(csr_a(0), 32'h0000FFFF);
      bus_rd(csr_a(0), d); check(d, 32'h00000337);
      bus_wr(csr_a(0), 32'h0);
   endtask

   // four channels with every request gate code, run together
   task automatic t_requests();
      logic [15:0] cfg [4];
      cfg = '{16'h0120, 16'h0110, 16'h0130, 16'h0100};
      for (int ch = 0; ch < 4; ch++) begin
         bus_wr(csr_a(ch) + CMTC_CONST_SUB, 32'h2);
         bus_wr(csr_a(ch), {16'h0, cfg[ch]});
      end
      bus_wr(CMTC_RUN_OFS, 32'h0000000F);
      for (int i = 0; i < 200 && ch_irq_r[0] !== 1'h1; i++) @(posedge clk);
      repeat (3) @(posedge clk);
      bus_wr(CMTC_RUN_OFS, 32'h0);
      check({27'h0, seen_irq}, 32'h1);
      check({27'h0, seen_dma}, 32'h2);
      for (int ch = 0; ch < 4; ch++) begin
         bus_rd(csr_a(ch), d); check(d, {16'h0, cfg[ch] | 16'h8000});
      end
      bus_rd(CMTC_IRQ_STAT_OFS, d); check(d, 32'h0000000F);
      check({31'h0, irq_r}, 32'h0);
      bus_wr(CMTC_IRQ_MASK_OFS, 32'h1);
      repeat (2) @(posedge clk);
      #1 check({31'h0, irq_r}, 32'h1);
      bus_wr(CMTC_IRQ_STAT_OFS, 32'h1);
      repeat (2) @(posedge clk);
      #1 check({31'h0, irq_r}, 32'h0);
      bus_wr(CMTC_IRQ_STAT_OFS, 32'hFFFF);
   endtask

   task automatic t_flag_clear();
      bus_wr(csr_a(0), 32'h8120);
      bus_wr(csr_a(0), 32'h0120);
      bus_rd(csr_a(0), d); check(d, 32'h8120);
      bus_wr(csr_a(0), 32'h0120);
      bus_rd(csr_a(0), d); check(d, 32'h0120);
   endtask

   task automatic t_oneshot();
      bus_wr(csr_a(4) + CMTC_CONST_SUB, 32'h2);
      bus_wr(CMTC_RUN_OFS, 32'h10);
      wait_csr(4, 32'h8000, d); check(d, 32'h8000);
      repeat (40) @(posedge clk);
      bus_rd(csr_a(4) + CMTC_CNT_SUB, d); check(d, 32'h0);
      bus_rd(csr_a(4), d);
      bus_wr(csr_a(4), 32'h0);
      repeat (10) @(posedge clk);
      bus_rd(csr_a(4) + CMTC_CNT_SUB, d); check({31'h0, d != 32'h0}, 32'h1);
      bus_wr(CMTC_RUN_OFS, 32'h0);
      bus_wr(CMTC_IRQ_STAT_OFS, 32'hFFFF);
   endtask

   task automatic t_width();
      bus_wr(csr_a(0) + CMTC_CONST_SUB, 32'hFFFFFFFF);
      bus_wr(csr_a(0), 32'h0100);
      bus_wr(csr_a(0) + CMTC_CNT_SUB, 32'h0000FFFF);
      bus_wr(CMTC_RUN_OFS, 32'h1);
      repeat (30) @(posedge clk);
      bus_wr(CMTC_RUN_OFS, 32'h0);
      bus_rd(csr_a(0) + CMTC_CNT_SUB, d); check(d >> 16, 32'h1);
      bus_rd(csr_a(0), d); check(d, 32'h0100);
      bus_wr(csr_a(0), 32'h0300);
      bus_wr(csr_a(0) + CMTC_CNT_SUB, 32'h0000FFFF);
      bus_wr(CMTC_RUN_OFS, 32'h1);
      wait_csr(0, 32'h4000, d);
      bus_wr(CMTC_RUN_OFS, 32'h0);
      check(d, 32'hC300);
      bus_rd(CMTC_IRQ_STAT_OFS, d); check(d, 32'h0101);
      bus_rd(csr_a(0) + CMTC_CNT_SUB, d); check(d >> 16, 32'h0);
      bus_rd(csr_a(0), d);
      bus_wr(csr_a(0), 32'h4300);
      bus_rd(csr_a(0), d); check(d, 32'h4300);
      bus_wr(csr_a(0), 32'h0300);
      bus_rd(csr_a(0), d); check(d, 32'h0300);
      // upper constant bits must drop out of the compare in 16-bit mode
      bus_wr(csr_a(0) + CMTC_CONST_SUB, 32'h00050002);
      bus_wr(csr_a(0) + CMTC_CNT_SUB, 32'h0);
      bus_wr(CMTC_RUN_OFS, 32'h1);
      wait_csr(0, 32'h8000, d);
      bus_wr(CMTC_RUN_OFS, 32'h0);
      check(d, 32'h8300);
   endtask

   // the run window spans whole divider periods, so the tick count is exact
   task automatic t_clock_select();
      for (int k = 1; k < 3; k++) begin
         bus_wr(csr_a(k) + CMTC_CONST_SUB, 32'hFFFFFFFF);
         bus_wr(csr_a(k) + CMTC_CNT_SUB, 32'h0);
         bus_wr(csr_a(k), 32'h0100 | k);
         bus_wr(CMTC_RUN_OFS, 32'h1 << k);
         // run stays set for the wait plus the two edges of the stopping write
         repeat (k == 1 ? 2 * CMTC_DIV_B - 2 : CMTC_DIV_C - 2) @(posedge clk);
         bus_wr(CMTC_RUN_OFS, 32'h0);
         bus_rd(csr_a(k) + CMTC_CNT_SUB, d); check(d, k == 1 ? 32'h2 : 32'h1);
      end
   endtask

   initial begin
      clk         = 1'h0;
      reset_n     = 1'h0;
      addr        = '0;
      wdata       = '0;
      wr          = 1'h0;
      rd          = 1'h0;
      seen_dma    = '0;
      seen_irq    = '0;
      fail_count  = 0;
      check_count = 0;
      cycles      = 0;
      repeat (12) @(posedge clk);
      reset_n <= 1'h1;
      t_reset_values();
      t_requests();
      t_flag_clear();
      t_oneshot();
      t_width();
      t_clock_select();
      wrap_up();
   end
endmodule
